// ---- hdl/ccm_coef_store.sv ----
// paged coefficient store for the codec filters, record and playback sides
// assumes a host port on mclk and filter readers on mclk; no clock crossing
`timescale 1ns/10ps
`include "ccm_defines.svh"

module ccm_coef_store
  import ccm_pkg::*;
(
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          rst,
  // host control port
  input  wire ccm_host_req_t hostReq,
  output logic [7:0]         rdData,
  output logic               rdValid,
  // record filter reader
  input  wire logic          adcBufB,
  input  wire logic [5:0]    adcIdx,
  output logic [31:0]        adcCoef,
  // playback filter reader
  input  wire logic          dacBufB,
  input  wire logic [6:0]    dacIdx,
  output logic [23:0]        dacCoef
);

  // ****************************************
  // decoding helpers
  // ****************************************

  // record reset value per coefficient index
  function automatic logic [31:0] adcDefault(input logic [5:0] idx);
    logic [31:0] v;
    v = `CCM_ADC_ZERO;
    unique case (idx)
      6'h01, 6'h02: v = `CCM_ADC_C1;
      6'h03:        v = `CCM_ADC_C3;
      6'h04, 6'h07, 6'h0c, 6'h11, 6'h16, 6'h1b: v = `CCM_ADC_UNITY;
      6'h24, 6'h27, 6'h2c, 6'h31, 6'h36, 6'h3b: v = `CCM_ADC_UNITY;
      default:      v = `CCM_ADC_ZERO;
    endcase
    return v;
  endfunction

  // page and register to playback slot
  function automatic ccm_slot_t decodeSlot(input logic [7:0] page, input logic [6:0] regNum);
    ccm_slot_t  s;
    logic [7:0] rel;
    logic [6:0] off;
    logic [8:0] full;
    s      = '0;
    off    = regNum - `CCM_COEF_REG_FIRST;
    s.lane = off[1:0];
    rel    = 8'hff;
    if (page >= `CCM_DAC_A_PAGE && page < `CCM_DAC_A_PAGE + `CCM_DAC_PAGES) begin
      rel = page - `CCM_DAC_A_PAGE;
    end
    else if (page >= `CCM_DAC_B_PAGE && page < `CCM_DAC_B_PAGE + `CCM_DAC_PAGES) begin
      rel    = page - `CCM_DAC_B_PAGE;
      s.bufB = 1'b1;
    end
    full  = {7'h00, rel[1:0]} * `CCM_SLOTS_PER_PAGE + {4'h0, off[6:2]};
    s.hit = (rel != 8'hff) && (regNum >= `CCM_COEF_REG_FIRST) && (full < `CCM_DAC_LAST);
    s.idx = full[6:0];
    return s;
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [7:0]  pageSel_r,  pageSel_nxt;
  logic [7:0]  rdData_r,   rdData_nxt;
  logic        rdValid_r,  rdValid_nxt;
  logic [31:0] adcCoef_r,  adcCoef_nxt;
  logic [23:0] dacCoef_r,  dacCoef_nxt;
  logic [31:0] adcMem_r [2][`CCM_ADC_NUM];
  logic [23:0] dacMem_r [2][`CCM_DAC_NUM];
  logic [23:0] dacMem_nxt [2][`CCM_DAC_NUM];
  ccm_slot_t   slot;
  logic [23:0] slotWord;

  assign slot = decodeSlot(pageSel_r, hostReq.addr);
  // word under the host slot, only meaningful while slot.hit
  assign slotWord = dacMem_r[slot.bufB][slot.idx];

  // ****************************************
  // record store: constant after reset
  // ****************************************

  // rebuilt from the default table on every reset, no host path into it
  generate
    for (genvar b = 0; b < 2; b++) begin : g_adcBuf
      for (genvar i = 0; i < `CCM_ADC_NUM; i++) begin : g_adcTap
        always_ff @(posedge mclk) begin
          if (rst) begin
            adcMem_r[b][i] <= adcDefault(6'(i));
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // host port and playback store
  // ****************************************

  // next values for page, readback and playback bytes
  always_comb begin
    pageSel_nxt = pageSel_r;
    rdData_nxt  = rdData_r;
    rdValid_nxt = hostReq.rd;
    dacMem_nxt  = dacMem_r;
    // read uses the page held before a same-cycle write
    if (hostReq.rd) begin
      rdData_nxt = 8'h00;
      if (hostReq.addr == `CCM_PAGE_REG) begin
        rdData_nxt = pageSel_r;
      end
      else if (slot.hit && slot.lane != `CCM_LANE_RESERVED) begin
        unique case (slot.lane)
          2'h0:    rdData_nxt = dacMem_r[slot.bufB][slot.idx][23:16];
          2'h1:    rdData_nxt = dacMem_r[slot.bufB][slot.idx][15:8];
          default: rdData_nxt = dacMem_r[slot.bufB][slot.idx][7:0];
        endcase
      end
    end
    if (hostReq.wr) begin
      if (hostReq.addr == `CCM_PAGE_REG) begin
        pageSel_nxt = hostReq.data;
      end
      else if (slot.hit) begin
        unique case (slot.lane)
          2'h0:    dacMem_nxt[slot.bufB][slot.idx][23:16] = hostReq.data;
          2'h1:    dacMem_nxt[slot.bufB][slot.idx][15:8]  = hostReq.data;
          2'h2:    dacMem_nxt[slot.bufB][slot.idx][7:0]   = hostReq.data;
          default: dacMem_nxt[slot.bufB][slot.idx]        = dacMem_r[slot.bufB][slot.idx];
        endcase
      end
    end
    // filter readers see one cycle of latency
    adcCoef_nxt = adcMem_r[adcBufB][adcIdx];
    dacCoef_nxt = (dacIdx < 7'(`CCM_DAC_NUM)) ? dacMem_r[dacBufB][dacIdx] : `CCM_DAC_RST;
  end

  // registers only
  always_ff @(posedge mclk) begin
    if (rst) begin
      pageSel_r <= `CCM_PAGE_RST;
      rdData_r  <= 8'h00;
      rdValid_r <= 1'b0;
      adcCoef_r <= `CCM_ADC_ZERO;
      dacCoef_r <= `CCM_DAC_RST;
      for (int b = 0; b < 2; b++) begin
        for (int i = 0; i < `CCM_DAC_NUM; i++) begin
          dacMem_r[b][i] <= `CCM_DAC_RST;
        end
      end
    end else begin
      pageSel_r <= pageSel_nxt;
      rdData_r  <= rdData_nxt;
      rdValid_r <= rdValid_nxt;
      adcCoef_r <= adcCoef_nxt;
      dacCoef_r <= dacCoef_nxt;
      dacMem_r  <= dacMem_nxt;
    end
  end

  assign rdData  = rdData_r;
  assign rdValid = rdValid_r;
  assign adcCoef = adcCoef_r;
  assign dacCoef = dacCoef_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_page_reset;
    $past(rst) |-> pageSel_r == `CCM_PAGE_RST;
  endproperty
  a_page_reset: assert property (p_page_reset) else $error("page not zero after reset");

  property p_page_write;
    hostReq.wr && hostReq.addr == `CCM_PAGE_REG && !hostReq.rd ##1 hostReq.rd && hostReq.addr == `CCM_PAGE_REG
      |=> rdData == $past(hostReq.data, 2) && rdValid;
  endproperty
  a_page_write: assert property (p_page_write) else $error("page readback wrong");

  property p_reserved_zero;
    hostReq.rd && hostReq.addr != `CCM_PAGE_REG && slot.lane == `CCM_LANE_RESERVED |=> rdData == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved byte not zero");

  property p_reserved_nowrite;
    hostReq.wr && slot.hit && slot.lane == `CCM_LANE_RESERVED
      |=> dacMem_r[$past(slot.bufB)][$past(slot.idx)] == $past(slotWord);
  endproperty
  a_reserved_nowrite: assert property (p_reserved_nowrite) else $error("reserved write changed slot");

  property p_high_byte;
    hostReq.wr && slot.hit && slot.lane == 2'h0 && hostReq.addr != `CCM_PAGE_REG
      |=> dacMem_r[$past(slot.bufB)][$past(slot.idx)][23:16] == $past(hostReq.data);
  endproperty
  a_high_byte: assert property (p_high_byte) else $error("high byte not stored");

  property p_last_a;
    hostReq.wr && pageSel_r == 8'h2e && hostReq.addr == 7'h48 |=> dacMem_r[0][76][23:16] == $past(hostReq.data);
  endproperty
  a_last_a: assert property (p_last_a) else $error("buffer A C76 misplaced");

  property p_first_b;
    hostReq.wr && pageSel_r == 8'h3e && hostReq.addr == 7'h0a |=> dacMem_r[1][0][7:0] == $past(hostReq.data);
  endproperty
  a_first_b: assert property (p_first_b) else $error("buffer B C0 misplaced");

  property p_adc_c3;
    adcIdx == 6'h03 |=> adcCoef == `CCM_ADC_C3;
  endproperty
  a_adc_c3: assert property (p_adc_c3) else $error("record C3 default wrong");

  property p_adc_c22;
    adcIdx == 6'h16 ##1 adcIdx == 6'h17 |-> adcCoef == `CCM_ADC_UNITY ##1 adcCoef == `CCM_ADC_ZERO;
  endproperty
  a_adc_c22: assert property (p_adc_c22) else $error("record C22/C23 default wrong");

  property p_adc_c59;
    adcIdx == 6'h3b |=> adcCoef == `CCM_ADC_UNITY;
  endproperty
  a_adc_c59: assert property (p_adc_c59) else $error("record C59 default wrong");

  c_page_write: cover property (hostReq.wr && hostReq.addr == `CCM_PAGE_REG);
  c_coef_read:  cover property (hostReq.rd && slot.hit && slot.lane == 2'h1);
  c_buf_b:      cover property (hostReq.wr && slot.hit && slot.bufB);
  c_adc_read:   cover property (adcBufB && adcIdx == 6'h24);

endmodule

// ---- hdl/ccm_defines.svh ----
// constants of the codec coefficient store: offsets, layout, reset values
// assumes inclusion by bare name from the package and the design module
`ifndef CCM_DEFINES_SVH
`define CCM_DEFINES_SVH

// ****************************************
// register layout inside a page
// ****************************************
`define CCM_PAGE_REG        7'h00
`define CCM_COEF_REG_FIRST  7'h08
`define CCM_PAGE_RST        8'h00
`define CCM_LANE_RESERVED   2'h3

// ****************************************
// playback buffer placement
// ****************************************
`define CCM_DAC_A_PAGE      8'h2c
`define CCM_DAC_B_PAGE      8'h3e
`define CCM_DAC_PAGES       8'h03
`define CCM_SLOTS_PER_PAGE  9'h01e
`define CCM_DAC_NUM         77
`define CCM_DAC_LAST        9'h04d
`define CCM_DAC_RST         24'h000000

// ****************************************
// record buffer reset values
// ****************************************
`define CCM_ADC_NUM         64
`define CCM_ADC_ZERO        32'h00000000
`define CCM_ADC_C1          32'h00170000
`define CCM_ADC_C3          32'h7dd30000
`define CCM_ADC_UNITY       32'h07ffff00

`endif

// ---- hdl/ccm_pkg.sv ----
// types shared by the coefficient store and its bench
// assumes ccm_defines.svh on the include path
package ccm_pkg;
  `include "ccm_defines.svh"

  // one host port request, taken in a single cycle
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] data;
  } ccm_host_req_t;

  // decoded position of a byte in the playback store
  typedef struct packed {
    logic       hit;
    logic       bufB;
    logic [6:0] idx;
    logic [1:0] lane;
  } ccm_slot_t;
endpackage

// ---- verif/ccm_coef_store_tb_top.sv ----
// bench for the coefficient store: record defaults, page select, playback bytes
// assumes the store alone on one 50 MHz clock, inputs driven at rising edges
`timescale 1ns/10ps

module ccm_coef_store_tb_top
  import ccm_pkg::*;
;
  logic          mclk;
  logic          rst;
  ccm_host_req_t hostReq;
  logic [7:0]    rdData;
  logic          rdValid;
  logic          adcBufB;
  logic [5:0]    adcIdx;
  logic [31:0]   adcCoef;
  logic          dacBufB;
  logic [6:0]    dacIdx;
  logic [23:0]   dacCoef;
  int            n_fail;
  int            n_tests;

  ccm_coef_store ccm_coef_store_i (
    .mclk    (mclk),
    .rst     (rst),
    .hostReq (hostReq),
    .rdData  (rdData),
    .rdValid (rdValid),
    .adcBufB (adcBufB),
    .adcIdx  (adcIdx),
    .adcCoef (adcCoef),
    .dacBufB (dacBufB),
    .dacIdx  (dacIdx),
    .dacCoef (dacCoef)
  );

  // 20 ns clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ************
  // shared tasks
  // ************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic hostOp(input logic wr, input logic rd, input logic [6:0] addr, input logic [7:0] data);
    @(posedge mclk);
    hostReq <= '{wr: wr, rd: rd, addr: addr, data: data};
  endtask

  task automatic idle();
    @(posedge mclk);
    hostReq <= '0;
  endtask

  // read answer lands one edge after the request, then drops again
  task automatic rdByte(input logic [6:0] addr, input logic [7:0] exp);
    hostOp(1'b0, 1'b1, addr, 8'h00);
    idle();
    #1;
    check(rdValid, 1'b1);
    check(rdData, exp);
    @(posedge mclk);
    #1;
    check(rdValid, 1'b0);
  endtask

  // page and slot base of playback coefficient n, page written here
  task automatic selCoef(input logic bufB, input int n, output logic [6:0] base);
    hostOp(1'b1, 1'b0, 7'h00, 8'(bufB ? 62 + n / 30 : 44 + n / 30));
    base = 7'(8 + 4 * (n % 30));
  endtask

  // junk into the reserved lane must leave the slot untouched
  task automatic wrCoef(input logic bufB, input int n, input logic [23:0] v);
    logic [6:0] b;
    // playback reader held still, as if powered down
    selCoef(bufB, n, b);
    hostOp(1'b1, 1'b0, b, v[23:16]);
    hostOp(1'b1, 1'b0, b + 7'h1, v[15:8]);
    hostOp(1'b1, 1'b0, b + 7'h2, v[7:0]);
    hostOp(1'b1, 1'b0, b + 7'h3, 8'ha5);
    idle();
  endtask

  task automatic chkCoef(input logic bufB, input int n, input logic [23:0] v);
    logic [6:0] b;
    selCoef(bufB, n, b);
    rdByte(b, v[23:16]);
    rdByte(b + 7'h1, v[15:8]);
    rdByte(b + 7'h2, v[7:0]);
    rdByte(b + 7'h3, 8'h00);
    @(posedge mclk);
    dacBufB <= bufB;
    dacIdx  <= 7'(n);
    @(posedge mclk);
    #1;
    check(dacCoef, v);
  endtask

  function automatic logic [31:0] adcExp(input int i);
    case (i)
      1, 2: return 32'h00170000;
      3: return 32'h7dd30000;
      4, 7, 12, 17, 22, 27, 36, 39, 44, 49, 54, 59: return 32'h07ffff00;
      default: return 32'h00000000;
    endcase
  endfunction

  // ************
  // scenarios
  // ************
  task automatic pageSelect();
    rdByte(7'h00, 8'h00);
    hostOp(1'b1, 1'b0, 7'h00, 8'h2e);
    rdByte(7'h00, 8'h2e);
    rdByte(7'h03, 8'h00);
  endtask

  // one index per cycle, so neighbouring taps follow back to back; answer checked one edge later
  task automatic recordDefaults();
    for (int b = 0; b < 2; b++) begin
      for (int i = 0; i <= 64; i++) begin
        @(posedge mclk);
        if (i < 64) begin
          adcBufB <= 1'(b);
          adcIdx  <= 6'(i);
        end
        #1;
        if (i > 0) begin
          check(adcCoef, adcExp(i - 1));
        end
      end
    end
  endtask

  // bit 31 buffer, bits 30:24 index, bits 23:0 value; page edges on purpose
  task automatic playback();
    logic [31:0] tv [7] = '{32'h00123456, 32'h1dabcdef, 32'h1e0f1e2d, 32'h4cc3b2a1,
                            32'h80654321, 32'hbb5a6b7c, 32'hcc98fedc};
    foreach (tv[i]) wrCoef(tv[i][31], int'(tv[i][30:24]), tv[i][23:0]);
    foreach (tv[i]) chkCoef(tv[i][31], int'(tv[i][30:24]), tv[i][23:0]);
  endtask

  // second reset in mid-run brings the selector back to zero
  task automatic resetAgain();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rdByte(7'h00, 8'h00);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    hostReq = '0;
    rst     = 1'b1;
    adcBufB = 1'b0;
    adcIdx  = 6'h00;
    dacBufB = 1'b0;
    dacIdx  = 7'h00;
    n_fail  = 0;
    n_tests = 0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    pageSelect();
    recordDefaults();
    playback();
    resetAgain();
    end_of_test();
  end

  // hang guard, far beyond the few hundred cycles needed
  initial begin
    #100000;
    n_fail++;
    end_of_test();
  end
endmodule
